/* File: hw/srw_pkg.sv */
// Constants and types for the serial register write port
`default_nettype none
package srw_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 6;
   localparam int FRAME_BITS = 16;
   localparam int NUM_REGS = 32;
   localparam int IDX_W = 5;
   localparam logic [4:0] BIT_LAST = 5'h0F;
   localparam logic [4:0] BIT_DATA0 = 5'h0A;
   localparam logic [5:0] REG_RESET = 6'h00;
   // Register offsets
   localparam logic [4:0] A_PWR_LO = 5'h00;
   localparam logic [4:0] A_PWR_HI = 5'h01;
   localparam logic [4:0] A_UPD_LO = 5'h19;
   localparam logic [4:0] A_UPD_HI = 5'h1A;
   localparam logic [4:0] A_HOLD = 5'h1B;
   localparam int HOLD_BIT = 0;
   // Low halves of double-wide registers
   localparam logic [NUM_REGS-1:0] PAIR_LO_MASK = 32'h0200_0015;
   // Registers that take effect at the strobe rising edge
   localparam logic [NUM_REGS-1:0] IMM_MASK = 32'h1880_0043;
   // Implemented data bits per register
   localparam logic [5:0] MASK_FULL = 6'h3F;
   localparam logic [5:0] MASK_2B = 6'h03;
   localparam logic [5:0] MASK_4B = 6'h0F;
   localparam logic [5:0] MASK_1B = 6'h01;
   localparam logic [4:0] A_GAIN_HI = 5'h03;
   localparam logic [4:0] A_BLACK_HI = 5'h05;
   localparam logic [NUM_REGS-1:0] ONE_BIT_MASK = 32'hD980_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } srw_wr_t;

   typedef enum logic [0:0] {SRW_ADDR, SRW_DATA} srw_phase_t;
endpackage
`default_nettype wire

/* File: hw/srw_port.sv */
// Serial register write port with strobe and sync-edge update
`default_nettype none
module srw_port
   import srw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial port pins
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_load_strobe,
   // Timing syncs
   input wire logic vertical_sync,
   input wire logic horizontal_sync,
   // Active register contents
   output logic [NUM_REGS-1:0][DATA_W-1:0] active_reg,
   output logic [2*DATA_W-1:0] power_state_select,
   output logic hold_pending_writes
);
   function automatic logic [5:0] data_mask(input logic [4:0] idx);
      if (ONE_BIT_MASK[idx])
         return MASK_1B;
      else if (idx == A_BLACK_HI)
         return MASK_2B;
      else if (idx == A_GAIN_HI)
         return MASK_4B;
      return MASK_FULL;
   endfunction

   // Two-flop synchronisers plus edge history
   logic [4:0] s1_reg, s2_reg, prev_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= 5'h1F;
         s2_reg <= 5'h1F;
         prev_reg <= 5'h1F;
      end else begin
         s1_reg <= {serial_clk, serial_data, serial_load_strobe, vertical_sync, horizontal_sync};
         s2_reg <= s1_reg;
         prev_reg <= s2_reg;
      end
   end
   wire sck_rise = s2_reg[4] & ~prev_reg[4];
   wire sd = s2_reg[3];
   wire strobe_low = ~s2_reg[2];
   wire strobe_fall = ~s2_reg[2] & prev_reg[2];
   wire strobe_rise = s2_reg[2] & ~prev_reg[2];
   wire vsync_fall = ~s2_reg[1] & prev_reg[1];
   wire hsync_fall = ~s2_reg[0] & prev_reg[0];

   // Frame parser; the serial port is the only write path
   logic [4:0] bit_cnt_reg, bit_cnt_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] dsh_reg, dsh_next;
   srw_phase_t phase;
   srw_wr_t wr;
   wire take_bit = strobe_low & ~strobe_fall & sck_rise;
   assign phase = (bit_cnt_reg < BIT_DATA0) ? SRW_ADDR : SRW_DATA;
   wire wr_valid = take_bit & (bit_cnt_reg == BIT_LAST);
   // One driver for the whole word keeps the struct single-sourced
   assign wr = '{addr: addr_reg, data: {sd, dsh_reg[DATA_W-1:1]}};
   wire wr_in_map = (wr.addr[ADDR_W-1:IDX_W] == '0);
   wire [IDX_W-1:0] wr_idx = wr.addr[IDX_W-1:0];

   always_comb begin
      bit_cnt_next = bit_cnt_reg;
      addr_next = addr_reg;
      dsh_next = dsh_reg;
      if (strobe_fall) begin
         bit_cnt_next = 5'h00;
      end else if (take_bit) begin
         if (phase == SRW_ADDR) begin
            addr_next = {sd, addr_reg[ADDR_W-1:1]};
         end else begin
            dsh_next = {sd, dsh_reg[DATA_W-1:1]};
         end
         if (bit_cnt_reg == BIT_LAST) begin
            bit_cnt_next = BIT_DATA0;
            addr_next = addr_reg + 10'h001;
         end else begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_reg <= 5'h00;
         addr_reg <= '0;
         dsh_reg <= '0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         addr_reg <= addr_next;
         dsh_reg <= dsh_next;
      end
   end

   // Staging, lower-half holding and pending flags
   logic [NUM_REGS-1:0][DATA_W-1:0] stage_reg;
   logic [NUM_REGS-1:0][DATA_W-1:0] lo_hold_reg;
   logic [NUM_REGS-1:0] pend_reg;
   wire is_lo = PAIR_LO_MASK[wr_idx];
   wire is_hi = (wr_idx != A_PWR_LO) & PAIR_LO_MASK[wr_idx - 5'h01];
   wire [IDX_W-1:0] lo_idx = wr_idx - 5'h01;
   wire [DATA_W-1:0] wr_masked = wr.data & data_mask(wr_idx);
   wire do_wr = wr_valid & wr_in_map;

   // Sync-edge line tracking
   logic armed_reg;
   logic [11:0] line_cnt_reg;
   wire [11:0] update_line = {active_reg[A_UPD_HI], active_reg[A_UPD_LO]};
   wire line_hit = armed_reg & hsync_fall & (line_cnt_reg == update_line);
   wire apply_sync = line_hit & ~hold_pending_writes;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_reg <= 1'b0;
         line_cnt_reg <= 12'h000;
      end else if (vsync_fall) begin
         armed_reg <= 1'b1;
         line_cnt_reg <= 12'h000;
      end else if (hsync_fall & armed_reg) begin
         armed_reg <= ~line_hit;
         line_cnt_reg <= line_cnt_reg + 12'h001;
      end
   end

   // Lone lower half only fills the holding latch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_reg <= '0;
         lo_hold_reg <= '0;
         pend_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if ((strobe_rise & IMM_MASK[i]) | (apply_sync & ~IMM_MASK[i]))
               pend_reg[i] <= 1'b0;
         end
         if (do_wr) begin
            if (is_lo) begin
               lo_hold_reg[wr_idx] <= wr_masked;
            end else begin
               stage_reg[wr_idx] <= wr_masked;
               pend_reg[wr_idx] <= 1'b1;
            end
            if (is_hi) begin
               // Unwritten lower half commits whatever the latch holds
               stage_reg[lo_idx] <= lo_hold_reg[lo_idx];
               pend_reg[lo_idx] <= 1'b1;
            end
         end
      end
   end

   // Active registers take staged values at the right edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         active_reg <= {NUM_REGS{REG_RESET}};
         power_state_select <= '0;
         hold_pending_writes <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (pend_reg[i] & IMM_MASK[i] & strobe_rise)
               active_reg[i] <= stage_reg[i];
            else if (pend_reg[i] & ~IMM_MASK[i] & apply_sync)
               active_reg[i] <= stage_reg[i];
         end
         power_state_select <= {active_reg[A_PWR_HI], active_reg[A_PWR_LO]};
         hold_pending_writes <= active_reg[A_HOLD][HOLD_BIT];
      end
   end

   // Checking helpers
   logic seen_wr_reg;
   logic [ADDR_W-1:0] last_addr_reg;
   logic [2:0] data_seen_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_wr_reg <= 1'b0;
         last_addr_reg <= '0;
         data_seen_reg <= 3'h0;
      end else begin
         if (strobe_fall)
            seen_wr_reg <= 1'b0;
         else if (wr_valid)
            seen_wr_reg <= 1'b1;
         if (wr_valid)
            last_addr_reg <= wr.addr;
         // Own data bit count, stepped only in the data phase that the parser counter sets
         if (strobe_fall | wr_valid)
            data_seen_reg <= 3'h0;
         else if (take_bit & (phase == SRW_DATA))
            data_seen_reg <= data_seen_reg + 3'h1;
      end
   end

   property p_write_full_frame;
      @(posedge clk) disable iff (!rst_b) wr_valid |-> data_seen_reg == 3'(DATA_W - 1);
   endproperty
   a_write_full_frame: assert property (p_write_full_frame)
      else $error("write without a full data word");

   property p_burst_incr;
      @(posedge clk) disable iff (!rst_b)
         wr_valid && seen_wr_reg |-> wr.addr == last_addr_reg + 10'h001;
   endproperty
   a_burst_incr: assert property (p_burst_incr)
      else $error("burst address did not step by one");

   property p_restart;
      @(posedge clk) disable iff (!rst_b) strobe_fall |=> bit_cnt_reg == 5'h00 && !wr_valid;
   endproperty
   a_restart: assert property (p_restart)
      else $error("strobe fall did not restart parsing");

   property p_imm_apply;
      @(posedge clk) disable iff (!rst_b)
         strobe_rise && pend_reg[A_PWR_LO] |=> active_reg[A_PWR_LO] == $past(stage_reg[A_PWR_LO]);
   endproperty
   a_imm_apply: assert property (p_imm_apply)
      else $error("strobe-updated register not applied");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
         hold_pending_writes && line_hit && !strobe_rise |=> $stable(active_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sync update while hold set");

   property p_lone_low;
      @(posedge clk) disable iff (!rst_b)
         do_wr && is_lo && !apply_sync |=> pend_reg == $past(pend_reg);
   endproperty
   a_lone_low: assert property (p_lone_low)
      else $error("lower half write changed pending state");

   property p_pair_commit;
      @(posedge clk) disable iff (!rst_b)
         do_wr && wr_idx == A_PWR_HI |=> pend_reg[A_PWR_LO] && pend_reg[A_PWR_HI]
            && stage_reg[A_PWR_LO] == $past(lo_hold_reg[A_PWR_LO]);
   endproperty
   a_pair_commit: assert property (p_pair_commit)
      else $error("double-wide register not committed");

   property p_line;
      @(posedge clk) disable iff (!rst_b) apply_sync |-> line_cnt_reg == update_line && hsync_fall;
   endproperty
   a_line: assert property (p_line)
      else $error("sync update on wrong line");

   property p_narrow;
      @(posedge clk) disable iff (!rst_b)
         do_wr && wr_idx == A_BLACK_HI |=> stage_reg[A_BLACK_HI][5:2] == 4'h0;
   endproperty
   a_narrow: assert property (p_narrow)
      else $error("unused bits stored in narrow register");

   c_burst: cover property (@(posedge clk) disable iff (!rst_b) wr_valid && seen_wr_reg);
   c_sync: cover property (@(posedge clk) disable iff (!rst_b) apply_sync && |pend_reg);
   c_imm: cover property (@(posedge clk) disable iff (!rst_b) strobe_rise && pend_reg[A_PWR_LO]);
   c_held: cover property (@(posedge clk) disable iff (!rst_b) line_hit && hold_pending_writes);
endmodule // srw_port
`default_nettype wire

/* File: testbench/srw_host_model.sv */
// Host model that writes registers over the three-wire port
`default_nettype none
module srw_host_model (
   // Serial pins
   output logic serial_clk,
   output logic serial_data,
   output logic serial_load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      serial_load_strobe = 1'b1;
   end
   // Data moves only while clock is low, held 160 ns past each rise
   task automatic put_bit(input logic b);
      serial_data = b;
      #160 serial_clk = 1'b1;
      #160 serial_clk = 1'b0;
   endtask
   // Tail bits make a partial word that must be dropped
   task automatic send(input logic [9:0] a, input logic [5:0] d[$], input int tail);
      serial_load_strobe = 1'b0;
      #160;
      for (int i = 0; i < 10; i++) put_bit(a[i]);
      foreach (d[k]) for (int j = 0; j < 6; j++) put_bit(d[k][j]);
      for (int j = 0; j < tail; j++) put_bit(1'b1);
      serial_load_strobe = 1'b1;
      // Released line must not keep showing the last bit
      serial_data = ~serial_data;
      #320;
   endtask
endmodule // srw_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the serial register write port
`default_nettype none
module testbench
   import srw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_b;
   logic vertical_sync;
   logic horizontal_sync;
   wire logic serial_clk;
   wire logic serial_data;
   wire logic serial_load_strobe;
   logic [NUM_REGS-1:0][DATA_W-1:0] active_reg;
   logic [2*DATA_W-1:0] power_state_select;
   logic hold_pending_writes;
   int err_total = 0;
   int comparisons = 0;

   srw_host_model u_host (.serial_clk(serial_clk), .serial_data(serial_data),
      .serial_load_strobe(serial_load_strobe));
   srw_port u_dut (.clk(clk), .rst_b(rst_b), .serial_clk(serial_clk),
      .serial_data(serial_data), .serial_load_strobe(serial_load_strobe),
      .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
      .active_reg(active_reg), .power_state_select(power_state_select),
      .hold_pending_writes(hold_pending_writes));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chk_reg(input logic [4:0] a, input logic [5:0] exp);
      check({6'h00, active_reg[a]}, {6'h00, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic line_sync_pulse();
      horizontal_sync = 1'b0;
      wt(8);
      horizontal_sync = 1'b1;
      wt(8);
   endtask
   // Frame sync, then the given number of line syncs
   task automatic sync_update(input int lines);
      vertical_sync = 1'b0;
      wt(8);
      vertical_sync = 1'b1;
      wt(8);
      repeat (lines) line_sync_pulse();
   endtask
   task automatic tally_and_finish();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run is near 80 us; five times that means a hang
   initial begin
      #400_000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      rst_b = 1'b0;
      vertical_sync = 1'b1;
      horizontal_sync = 1'b1;
      wt(16);
      rst_b = 1'b1;
      wt(4);
      check(power_state_select, 12'h000);
      check({11'h000, hold_pending_writes}, 12'h000);
      $display("test reset done");
      u_host.send(10'h006, '{6'h05}, 3);
      wt(2);
      chk_reg(5'h06, 6'h05);
      u_host.send(10'h000, '{6'h2A, 6'h3F}, 0);
      wt(2);
      chk_reg(5'h00, 6'h2A);
      check(power_state_select, 12'hFEA);
      u_host.send(10'h000, '{6'h11}, 0);
      wt(2);
      check(power_state_select, 12'hFEA);
      u_host.send(10'h001, '{6'h05}, 0);
      wt(2);
      chk_reg(5'h01, 6'h05);
      u_host.send(10'h020, '{6'h3F}, 0);
      wt(2);
      chk_reg(5'h01, 6'h05);
      $display("test strobe updates done");
      u_host.send(10'h005, '{6'h3F}, 0);
      u_host.send(10'h019, '{6'h01, 6'h00}, 0);
      chk_reg(5'h05, 6'h00);
      sync_update(1);
      chk_reg(5'h05, 6'h03);
      chk_reg(5'h07, 6'h00);
      chk_reg(5'h19, 6'h01);
      u_host.send(10'h00B, '{6'h01, 6'h02, 6'h03}, 0);
      sync_update(1);
      chk_reg(5'h0B, 6'h00);
      line_sync_pulse();
      chk_reg(5'h0B, 6'h01);
      chk_reg(5'h0D, 6'h03);
      $display("test sync updates done");
      u_host.send(10'h01B, '{6'h01}, 0);
      wt(2);
      check({11'h000, hold_pending_writes}, 12'h001);
      u_host.send(10'h00B, '{6'h3C}, 0);
      sync_update(2);
      chk_reg(5'h0B, 6'h01);
      u_host.send(10'h01B, '{6'h00}, 0);
      sync_update(2);
      chk_reg(5'h0B, 6'h3C);
      $display("test hold done");
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
